//--- rtl/ifs_defs.svh
// Register offsets, field positions and reset values of the input status readback bank
`ifndef IFS_DEFS_SVH
`define IFS_DEFS_SVH
`define IFS_ADDR_W 8
`define IFS_DATA_W 8
`define IFS_RSV_LO_FIRST 8'h5e
`define IFS_RSV_LO_LAST 8'h63
`define IFS_STATUS_ADDR 8'h64
`define IFS_RSV_HI_FIRST 8'h65
`define IFS_RSV_HI_LAST 8'h6d
`define IFS_FB1_ADDR 8'h6e
`define IFS_FB2_ADDR 8'h71
`define IFS_BIT_DOP 3
`define IFS_BIT_SPDIF 2
`define IFS_BIT_I2S 1
`define IFS_BIT_DSD 0
`define IFS_STATUS_RSV_VAL 4'h0
`define IFS_STATUS_RESET 8'h00
`define IFS_FB_RESET 24'h000000
`define IFS_FB_BYTES 3
`endif

//--- rtl/ifs_pkg.sv
// Types of the input status readback bank
package ifs_pkg;
    typedef enum logic [1:0] {
        IFS_SRC_NONE = 2'b00,
        IFS_SRC_I2S = 2'b01,
        IFS_SRC_SPDIF = 2'b11,
        IFS_SRC_DSD = 2'b10
    } ifs_src_t;
endpackage : ifs_pkg

//--- rtl/ifs_fb_if.sv
// Interface carrying one 24-bit feedback value and its byte selection
`timescale 1ns/1ps
`include "ifs_defs.svh"
interface ifs_fb_if;
    logic [23:0] value;
    logic [1:0] sel;
    logic [7:0] byte_out;
    modport src (input sel, input value, output byte_out);
    modport dst (output sel, output value, input byte_out);
endinterface : ifs_fb_if

//--- rtl/ifs_byte_sel.sv
// Byte selector for a 24-bit multi-register readback value
`timescale 1ns/1ps
`include "ifs_defs.svh"
module ifs_byte_sel
    import ifs_pkg::*;
(
    ifs_fb_if.src fb
);
    // Low byte at lowest register number
    always_comb begin
        case (fb.sel)
            2'h0: fb.byte_out = fb.value[7:0];
            2'h1: fb.byte_out = fb.value[15:8];
            2'h2: fb.byte_out = fb.value[23:16];
            default: fb.byte_out = 8'h00;
        endcase
    end
endmodule : ifs_byte_sel

//--- rtl/ifs_status_bank.sv
// Input lock status and feedback scale readback register bank
// Summary of operation
// - Status bit 3 reads 1 while a valid DSD-over-PCM stream is detected on I2S or SPDIF, else 0.
// - Status bit 2 reads 1 once valid SPDIF frames are decoded, 0 while none can be decoded.
// - Status bit 1 reads 1 when a valid frame and bit clock arrangement is seen, else 0.
// - Status bit 0 reads 1 only when DSD is used as fallback because I2S and SPDIF both fail.
// - The status register at 100 is read-only, its top four bits read zero and it resets to zero.
// - Registers 110 to 112 present the read-only 24-bit first feedback scale value, reset zero.
// - Registers 113 to 115 present the read-only 24-bit second feedback scale value, reset zero.
// - Registers 94 to 99 and 101 to 109 are reserved, read-only and read zero.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "ifs_defs.svh"
module ifs_status_bank
    import ifs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [`IFS_ADDR_W-1:0] i_addr,
    input wire logic [`IFS_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_dop_detect,
    input wire logic i_spdif_lock,
    input wire logic i_i2s_lock,
    input wire logic i_dsd_active,
    input wire logic [23:0] i_fb1_value,
    input wire logic [23:0] i_fb2_value,
    output logic [`IFS_DATA_W-1:0] o_rdata,
    output logic [3:0] o_status,
    output logic [1:0] o_source
);
    // ==========================================================
    // Status capture
    logic dop_valid;
    logic spdif_select;
    logic i2s_select;
    logic dsd_select;
    logic [23:0] fb1;
    logic [23:0] fb2;
    ifs_src_t source;
    // One flop from decoder level to readback; o_status adds a second

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            dop_valid <= 1'b0;
            spdif_select <= 1'b0;
            i2s_select <= 1'b0;
            dsd_select <= 1'b0;
        end else begin
            dop_valid <= i_dop_detect & (i_i2s_lock | i_spdif_lock);
            spdif_select <= i_spdif_lock;
            i2s_select <= i_i2s_lock;
            dsd_select <= i_dsd_active & ~i_i2s_lock & ~i_spdif_lock;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            fb1 <= `IFS_FB_RESET;
            fb2 <= `IFS_FB_RESET;
        end else begin
            fb1 <= i_fb1_value;
            fb2 <= i_fb2_value;
        end
    end

    // Priority: I2S ahead of SPDIF, DSD only as fallback
    // o_source is an observation port only; software never reads it
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            source <= IFS_SRC_NONE;
        end else if (i_i2s_lock) begin
            source <= IFS_SRC_I2S;
        end else if (i_spdif_lock) begin
            source <= IFS_SRC_SPDIF;
        end else if (i_dsd_active) begin
            source <= IFS_SRC_DSD;
        end else begin
            source <= IFS_SRC_NONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_status <= 4'h0;
            o_source <= 2'b00;
        end else begin
            o_status <= {dop_valid, spdif_select, i2s_select, dsd_select};
            o_source <= source;
        end
    end

    // ==========================================================
    // Byte selection for readback values
    ifs_fb_if fb1_if ();
    ifs_fb_if fb2_if ();
    assign fb1_if.value = fb1;
    assign fb2_if.value = fb2;
    assign fb1_if.sel = 2'(i_addr - `IFS_FB1_ADDR);
    assign fb2_if.sel = 2'(i_addr - `IFS_FB2_ADDR);
    ifs_byte_sel u_fb1 (.fb(fb1_if));
    ifs_byte_sel u_fb2 (.fb(fb2_if));

    // ==========================================================
    // Register read port
    // Writes are ignored: every location is read-only
    // Register numbers double as byte addresses on the 8-bit port
    logic [`IFS_DATA_W-1:0] next_rdata;
    always_comb begin
        if (i_addr == `IFS_STATUS_ADDR) begin
            next_rdata = {`IFS_STATUS_RSV_VAL, dop_valid, spdif_select, i2s_select, dsd_select};
        end else if (i_addr >= `IFS_FB1_ADDR && i_addr < `IFS_FB2_ADDR) begin
            next_rdata = fb1_if.byte_out;
        end else if (i_addr >= `IFS_FB2_ADDR && i_addr < `IFS_FB2_ADDR + 8'(`IFS_FB_BYTES)) begin
            next_rdata = fb2_if.byte_out;
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // Checks
    logic [`IFS_DATA_W-1:0] unused_wdata;
    assign unused_wdata = i_wdata & {8{i_wr}};

    // ==========================================================
    // Reset values, checked at the first edge after release
    // fb copies its input one edge later, so its reset value lives one cycle
    AST_RST_STATUS: assert property (@(posedge i_clk)
        i_resetn && !$past(i_resetn) |-> o_status == 4'h0 && o_rdata == 8'h00 && o_source == 2'b00)
        else $error("status not cleared by reset");
    AST_RST_FB1: assert property (@(posedge i_clk)
        i_resetn && !$past(i_resetn) |-> fb1 == `IFS_FB_RESET)
        else $error("fb1 not cleared by reset");
    AST_RST_FB2: assert property (@(posedge i_clk)
        i_resetn && !$past(i_resetn) |-> fb2 == `IFS_FB_RESET)
        else $error("fb2 not cleared by reset");

    // ==========================================================
    // Status bits reach o_status two edges after the decoder levels
    AST_DOP: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_dop_detect && i_i2s_lock |=> ##1 o_status[3])
        else $error("dop bit not set");
    AST_DOP_CLR: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!i_dop_detect || (!i_i2s_lock && !i_spdif_lock)) |=> ##1 !o_status[3])
        else $error("dop bit set without cause");
    AST_SPDIF: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_spdif_lock |=> ##1 !o_status[2])
        else $error("spdif bit set without lock");
    AST_SPDIF_SET: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_spdif_lock |=> ##1 o_status[2])
        else $error("spdif bit not set");
    AST_I2S: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_i2s_lock |=> ##1 o_status[1])
        else $error("i2s bit not set");
    AST_I2S_CLR: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_i2s_lock |=> ##1 !o_status[1])
        else $error("i2s bit set without lock");
    AST_DSD: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_status[0] |-> $past(i_dsd_active, 2) && !$past(i_i2s_lock, 2) && !$past(i_spdif_lock, 2))
        else $error("dsd fallback without cause");
    AST_DSD_SET: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_dsd_active && !i_i2s_lock && !i_spdif_lock |=> ##1 o_status[0])
        else $error("dsd fallback bit not set");
    AST_SRC_DSD: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_source == IFS_SRC_DSD |-> o_status[0])
        else $error("dsd source without fallback bit");

    // ==========================================================
    // Readback, one byte per register, low byte first
    // No snapshot: the three bytes of a value are read separately
    AST_STATUS_READ: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == `IFS_STATUS_ADDR |=> o_rdata[7:4] == 4'h0 && o_rdata[3:0] == o_status)
        else $error("status readback mismatch");
    AST_FB1_LO: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == `IFS_FB1_ADDR |=> o_rdata == $past(fb1[7:0]))
        else $error("fb1 low byte wrong");
    AST_FB1_MID: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == `IFS_FB1_ADDR + 8'h01 |=> o_rdata == $past(fb1[15:8]))
        else $error("fb1 middle byte wrong");
    AST_FB1: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == `IFS_FB1_ADDR + 8'h02 |=> o_rdata == $past(fb1[23:16]))
        else $error("fb1 high byte wrong");
    AST_FB2: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == `IFS_FB2_ADDR |=> o_rdata == $past(fb2[7:0]))
        else $error("fb2 low byte wrong");
    AST_FB2_MID: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == `IFS_FB2_ADDR + 8'h01 |=> o_rdata == $past(fb2[15:8]))
        else $error("fb2 middle byte wrong");
    AST_FB2_HI: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr == `IFS_FB2_ADDR + 8'h02 |=> o_rdata == $past(fb2[23:16]))
        else $error("fb2 high byte wrong");
    AST_RSV: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr >= `IFS_RSV_LO_FIRST && i_addr <= `IFS_RSV_LO_LAST |=> o_rdata == 8'h00)
        else $error("reserved reads nonzero");
    AST_RSV_HI: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_rd && i_addr >= `IFS_RSV_HI_FIRST && i_addr <= `IFS_RSV_HI_LAST |=> o_rdata == 8'h00)
        else $error("upper reserved reads nonzero");
    AST_WR_NOEFFECT: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_wr && !i_rd |=> o_rdata == 8'h00)
        else $error("write produced read data");

    // ==========================================================
    // Coverage of the main scenarios
    COV_STATUS: cover property (@(posedge i_clk) disable iff (!i_resetn) i_rd && i_addr == `IFS_STATUS_ADDR);
    COV_FB1: cover property (@(posedge i_clk) disable iff (!i_resetn) i_rd && i_addr == `IFS_FB1_ADDR);
    COV_DSD: cover property (@(posedge i_clk) disable iff (!i_resetn) o_status[0]);
    COV_FB2: cover property (@(posedge i_clk) disable iff (!i_resetn) i_rd && i_addr == `IFS_FB2_ADDR);
    COV_DOP: cover property (@(posedge i_clk) disable iff (!i_resetn) o_status[3]);
endmodule : ifs_status_bank

//--- bench/ifs_audio_src.sv
// Behavioural digital audio source driving decoder lock levels and feedback values
`timescale 1ns/1ps
module ifs_audio_src (
    input wire logic i_clk,
    input wire logic [3:0] i_flags,
    input wire logic [47:0] i_fb,
    output logic [3:0] o_flags,
    output logic [47:0] o_fb
);
    // Decoders settle one cycle after the source changes, never sooner
    always_ff @(posedge i_clk) begin
        o_flags <= i_flags;
        o_fb <= i_fb;
    end
endmodule : ifs_audio_src

//--- bench/testbench.sv
// Self-checking bench for the input status readback bank
`timescale 1ns/1ps
module testbench
    import ifs_pkg::*;
;
    logic i_clk, i_resetn, i_wr, i_rd;
    logic [7:0] i_addr, i_wdata, o_rdata, exp_st;
    logic [3:0] flags, src_flags, o_status;
    logic [47:0] fb, src_fb;
    logic [1:0] o_source;
    logic [1:0] exp_src;
    int miscompares, tests_run;
    ifs_audio_src i_ifs_audio_src (.i_clk(i_clk), .i_flags(flags), .i_fb(fb), .o_flags(src_flags), .o_fb(src_fb));
    ifs_status_bank i_ifs_status_bank (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_dop_detect(src_flags[3]), .i_spdif_lock(src_flags[2]),
        .i_i2s_lock(src_flags[1]), .i_dsd_active(src_flags[0]), .i_fb1_value(src_fb[23:0]),
        .i_fb2_value(src_fb[47:24]), .o_rdata(o_rdata), .o_status(o_status), .o_source(o_source));
    // ==========
    // Clock, bus tasks, verdict
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= addr;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk("rdata", exp, o_rdata);
    endtask : rd
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= addr;
        i_wdata <= data;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic report_and_stop;
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    // ==========
    // Tests
    initial begin
        i_resetn = 1'b0;
        i_rd = 1'b0;
        i_wr = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        flags = 4'hf;
        fb = 48'hffffffffffff;
        miscompares = 0;
        tests_run = 0;
        // Inputs busy during reset must not leak into the reset values
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        i_rd <= 1'b1;
        i_addr <= 8'h64;
        #1 chk("status_rst", 8'h00, {4'h0, o_status});
        chk("rdata_rst", 8'h00, o_rdata);
        // Read in the release cycle still sees the reset status
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk("status_dflt", 8'h00, o_rdata);
        for (int m = 0; m < 16; m++) begin
            @(posedge i_clk);
            flags <= m[3:0];
            repeat (3) @(posedge i_clk);
            exp_st = {4'h0, m[3] & (m[1] | m[2]), m[2], m[1], m[0] & ~m[1] & ~m[2]};
            exp_src = m[1] ? IFS_SRC_I2S : m[2] ? IFS_SRC_SPDIF : m[0] ? IFS_SRC_DSD : IFS_SRC_NONE;
            wr(8'h64, 8'hff);
            rd(8'h64, exp_st);
            chk("status", exp_st, {4'h0, o_status});
            chk("source", {6'h00, exp_src}, {6'h00, o_source});
            @(posedge i_clk);
            #1 chk("rdata_idle", 8'h00, o_rdata);
        end
        @(posedge i_clk);
        fb <= 48'ha5c3e15a3c1e;
        repeat (3) @(posedge i_clk);
        wr(8'h6e, 8'h00);
        wr(8'h73, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rd(8'h6e + i[7:0], fb[8*i +: 8]);
        end
        for (int a = 8'h5e; a < 8'h6e; a++) begin
            if (a != 8'h64) begin
                rd(a[7:0], 8'h00);
            end
        end
        wr(8'h60, 8'hff);
        rd(8'h60, 8'h00);
        rd(8'h74, 8'h00);
        rd(8'hff, 8'h00);
        // Mid-run reset: fb2 shows its reset value in the release cycle
        @(posedge i_clk);
        i_resetn <= 1'b0;
        @(posedge i_clk);
        i_resetn <= 1'b1;
        i_rd <= 1'b1;
        i_addr <= 8'h71;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk("fb2_dflt", 8'h00, o_rdata);
        report_and_stop();
    end
    initial begin
        #20000;
        miscompares++;
        report_and_stop();
    end
endmodule : testbench
